// ---- hpsc_pkg.sv ----
package hpsc_pkg;
  localparam logic [11:0] HPSC_SLOT_CTRL_OFF = 12'h0D8;
  localparam logic [11:0] HPSC_INT_STAT_OFF = 12'h0E0;
  localparam logic [11:0] HPSC_INT_MASK_OFF = 12'h0E4;
  localparam int HPSC_ATTN_BTN_BIT = 0;
  localparam int HPSC_PWR_FAULT_BIT = 1;
  localparam int HPSC_PRES_DET_BIT = 3;
  localparam int HPSC_CMD_DONE_BIT = 4;
  localparam int HPSC_MASTER_BIT = 5;
  localparam int HPSC_ATTN_IND_LSB = 6;
  localparam int HPSC_PWR_IND_LSB = 8;
  localparam int HPSC_PWR_CTRL_BIT = 10;
  localparam int HPSC_DLL_CHG_BIT = 12;
  localparam logic [15:0] HPSC_CTRL_WMASK = 16'h17FB;
  localparam logic [15:0] HPSC_CTRL_RESET = 16'h03C0;
  localparam logic [4:0] HPSC_EVT_RESET = 5'h00;
  localparam logic [1:0] HPSC_IND_ON = 2'h1;
  localparam logic [1:0] HPSC_IND_BLINK = 2'h2;
  localparam logic [1:0] HPSC_IND_OFF = 2'h3;

  typedef struct packed {
    logic dll_chg;
    logic cmd_done;
    logic pres_det;
    logic pwr_fault;
    logic attn_btn;
  } hpsc_evt_type;

  typedef struct packed {
    logic valid;
    logic is_power;
    logic [1:0] state;
  } hpsc_ind_msg_type;
endpackage

// ---- hpsc_slot_control.sv ----
// Function
// - Slot control at D8h, downstream ports only
// - Bit 0 gates attention button notification
// - Bit 1 gates power fault notification
// - Bit 3 gates presence change interrupt
// - Bit 4 gates command completed interrupt
// - Bit 5 master enables enabled events
// - Bits 7:6 drive attention indicator state
// - Bits 9:8 drive power indicator, reset off
// - Indicator write sends matching indicator message
// - Bit 10 one turns slot power off
// - Bit 12 gates link active change notification
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module hpsc_slot_control #(
  parameter bit DOWNSTREAM = 1'b1,
  parameter bit DLL_ACTIVE_CAP = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Slot events, single-cycle pulses from core logic
  input wire hpsc_pkg::hpsc_evt_type slot_evt,
  // Slot outputs
  output logic [1:0] attn_ind,
  output logic [1:0] pwr_ind,
  output logic slot_pwr_off,
  output hpsc_pkg::hpsc_ind_msg_type ind_msg,
  output logic hp_notify,
  output logic irq
);
  import hpsc_pkg::*;

  logic [15:0] ctrl_ff;
  logic [15:0] nxt_ctrl;
  logic [4:0] stat_ff;
  wire [4:0] nxt_stat;
  logic [4:0] mask_ff;
  logic [4:0] nxt_mask;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pready_ff;
  logic pslverr_ff;
  logic irq_ff;
  logic notify_ff;
  hpsc_ind_msg_type msg_ff;
  hpsc_ind_msg_type nxt_msg;

  wire setup_ph = psel && !penable;
  wire sel_ctrl = DOWNSTREAM && (paddr == HPSC_SLOT_CTRL_OFF);
  wire sel_stat = (paddr == HPSC_INT_STAT_OFF);
  wire sel_mask = (paddr == HPSC_INT_MASK_OFF);
  wire hit = sel_ctrl || sel_stat || sel_mask;
  wire acc = psel && penable && pready_ff;
  wire wr_ctrl = acc && pwrite && sel_ctrl;
  wire rd_stat = acc && !pwrite && sel_stat;
  wire wr_mask = acc && pwrite && sel_mask;

  // Per-event enables from control bits
  wire [4:0] evt_en = {ctrl_ff[HPSC_DLL_CHG_BIT] && DLL_ACTIVE_CAP,
                       ctrl_ff[HPSC_CMD_DONE_BIT],
                       ctrl_ff[HPSC_PRES_DET_BIT],
                       ctrl_ff[HPSC_PWR_FAULT_BIT],
                       ctrl_ff[HPSC_ATTN_BTN_BIT]};
  wire [4:0] evt_in = slot_evt;
  wire [4:0] evt_hit = evt_in & evt_en & {5{ctrl_ff[HPSC_MASTER_BIT]}};

  assign nxt_ctrl = wr_ctrl ? ((pwdata[15:0] & HPSC_CTRL_WMASK) |
                               (ctrl_ff & ~HPSC_CTRL_WMASK)) : ctrl_ff;
  // Status bits: read clears only what the read reported, set wins
  for (genvar g = 0; g < 5; g++) begin : g_stat
    wire clr_bit = rd_stat && prdata_ff[g];
    assign nxt_stat[g] = (stat_ff[g] && !clr_bit) || evt_hit[g];
  end
  assign nxt_mask = wr_mask ? pwdata[4:0] : mask_ff;
  assign nxt_prdata = !setup_ph ? prdata_ff :
                      (pwrite || !hit) ? 32'h0000_0000 :
                      sel_ctrl ? {16'h0000, ctrl_ff} :
                      sel_stat ? {27'h0, stat_ff} : {27'h0, mask_ff};
  // two messages per control write, attention message first, power message one cycle later
  function automatic logic [1:0] ind_field(input logic [15:0] v, input int lsb);
    return v[lsb +: 2];
  endfunction

  assign nxt_msg = wr_ctrl ? '{valid: 1'b1, is_power: 1'b0,
                               state: ind_field(pwdata[15:0], HPSC_ATTN_IND_LSB)} :
                   '{valid: 1'b0, is_power: 1'b0, state: 2'h0};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= HPSC_CTRL_RESET;
      stat_ff <= HPSC_EVT_RESET;
      mask_ff <= HPSC_EVT_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
    end
  end

  logic pend_pwr_ff;
  logic [1:0] pend_state_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      msg_ff <= '{valid: 1'b0, is_power: 1'b0, state: 2'h0};
      pend_pwr_ff <= 1'b0;
      pend_state_ff <= 2'h0;
    end else if (wr_ctrl) begin
      msg_ff <= nxt_msg;
      pend_pwr_ff <= 1'b1;
      pend_state_ff <= ind_field(pwdata[15:0], HPSC_PWR_IND_LSB);
    end else if (pend_pwr_ff) begin
      msg_ff <= '{valid: 1'b1, is_power: 1'b1, state: pend_state_ff};
      pend_pwr_ff <= 1'b0;
    end else begin
      msg_ff <= '{valid: 1'b0, is_power: 1'b0, state: 2'h0};
    end
  end

  // Bus response
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff <= nxt_prdata;
      pready_ff <= setup_ph;
      pslverr_ff <= setup_ph && !hit;
    end
  end

  // Interrupt level and notification pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_ff <= 1'b0;
      notify_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_stat & mask_ff);
      notify_ff <= |evt_hit;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign attn_ind = ind_field(ctrl_ff, HPSC_ATTN_IND_LSB);
  assign pwr_ind = ind_field(ctrl_ff, HPSC_PWR_IND_LSB);
  assign slot_pwr_off = ctrl_ff[HPSC_PWR_CTRL_BIT];
  assign ind_msg = msg_ff;
  assign hp_notify = notify_ff;
  assign irq = irq_ff;

  sequence ctrl_write_s;
    psel && penable && pready && pwrite && paddr == HPSC_SLOT_CTRL_OFF;
  endsequence

  attn_btn_gate_a: assert property (@(posedge clk) disable iff (rst)
    slot_evt.attn_btn && !ctrl_ff[HPSC_ATTN_BTN_BIT] && !(|(slot_evt & ~5'h01))
      |=> !hp_notify)
    else $error("attention event notified while disabled");
  pwr_fault_a: assert property (@(posedge clk) disable iff (rst)
    slot_evt.pwr_fault && ctrl_ff[HPSC_PWR_FAULT_BIT] && ctrl_ff[HPSC_MASTER_BIT]
      |=> hp_notify && stat_ff[1])
    else $error("power fault not notified");
  pres_det_a: assert property (@(posedge clk) disable iff (rst)
    slot_evt.pres_det && ctrl_ff[HPSC_PRES_DET_BIT] && ctrl_ff[HPSC_MASTER_BIT]
      |=> stat_ff[2])
    else $error("presence change not latched");
  cmd_done_a: assert property (@(posedge clk) disable iff (rst)
    slot_evt.cmd_done && ctrl_ff[HPSC_CMD_DONE_BIT] && ctrl_ff[HPSC_MASTER_BIT]
      |=> hp_notify)
    else $error("command completion not notified");
  master_off_a: assert property (@(posedge clk) disable iff (rst)
    !ctrl_ff[HPSC_MASTER_BIT] |=> !hp_notify)
    else $error("notification with master enable clear");
  ind_follow_a: assert property (@(posedge clk) disable iff (rst)
    ctrl_write_s |=> attn_ind == $past(pwdata[7:6]) && pwr_ind == $past(pwdata[9:8]))
    else $error("indicator outputs do not follow write");
  ind_msg_a: assert property (@(posedge clk) disable iff (rst)
    ctrl_write_s |=> ind_msg.valid && !ind_msg.is_power ##1 ind_msg.valid && ind_msg.is_power)
    else $error("indicator messages not sent");
  pwr_ctrl_a: assert property (@(posedge clk) disable iff (rst)
    ctrl_write_s |=> slot_pwr_off == $past(pwdata[10]))
    else $error("power control bit not applied");
  rsvd_zero_a: assert property (@(posedge clk) disable iff (rst)
    ctrl_ff[2] == 1'b0 && ctrl_ff[11] == 1'b0 && ctrl_ff[15:13] == 3'h0)
    else $error("reserved bits set");

  sequence enabled_evt_s;
    ctrl_ff[HPSC_MASTER_BIT] && |(slot_evt & evt_en);
  endsequence

  sequence attn_msg_s(logic [1:0] st);
    ind_msg.valid && !ind_msg.is_power && ind_msg.state == st;
  endsequence

  sequence pwr_msg_s(logic [1:0] st);
    ind_msg.valid && ind_msg.is_power && ind_msg.state == st;
  endsequence

  sequence stat_read_s;
    psel && penable && pready && !pwrite && paddr == HPSC_INT_STAT_OFF;
  endsequence

  sequence mask_write_s;
    psel && penable && pready && pwrite && paddr == HPSC_INT_MASK_OFF;
  endsequence

  sequence ctrl_read_s;
    psel && !penable && !pwrite && paddr == HPSC_SLOT_CTRL_OFF;
  endsequence

  // Event gating
  attn_btn_on_a: assert property (@(posedge clk) disable iff (rst)
    slot_evt.attn_btn && ctrl_ff[HPSC_ATTN_BTN_BIT] && ctrl_ff[HPSC_MASTER_BIT]
      |=> hp_notify && stat_ff[0])
    else $error("enabled attention event not notified");

  pwr_fault_off_a: assert property (@(posedge clk) disable iff (rst)
    slot_evt.pwr_fault && !ctrl_ff[HPSC_PWR_FAULT_BIT] && !(|(slot_evt & ~5'h02))
      |=> !hp_notify)
    else $error("power fault notified while disabled");

  pres_det_off_a: assert property (@(posedge clk) disable iff (rst)
    slot_evt.pres_det && !ctrl_ff[HPSC_PRES_DET_BIT] && !(|(slot_evt & ~5'h04))
      |=> !hp_notify)
    else $error("presence change notified while disabled");

  cmd_done_off_a: assert property (@(posedge clk) disable iff (rst)
    slot_evt.cmd_done && !ctrl_ff[HPSC_CMD_DONE_BIT] && !(|(slot_evt & ~5'h08))
      |=> !hp_notify)
    else $error("command completion notified while disabled");

  dll_chg_on_a: assert property (@(posedge clk) disable iff (rst)
    DLL_ACTIVE_CAP && slot_evt.dll_chg && ctrl_ff[HPSC_DLL_CHG_BIT] && ctrl_ff[HPSC_MASTER_BIT]
      |=> hp_notify && stat_ff[4])
    else $error("link state change not notified");

  dll_chg_off_a: assert property (@(posedge clk) disable iff (rst)
    slot_evt.dll_chg && !(ctrl_ff[HPSC_DLL_CHG_BIT] && DLL_ACTIVE_CAP) && !(|(slot_evt & ~5'h10))
      |=> !hp_notify)
    else $error("link state change notified while disabled");

  master_on_a: assert property (@(posedge clk) disable iff (rst)
    enabled_evt_s |=> hp_notify)
    else $error("enabled event not notified");

  stat_set_a: assert property (@(posedge clk) disable iff (rst)
    enabled_evt_s |=> (stat_ff & $past(slot_evt & evt_en)) == $past(slot_evt & evt_en))
    else $error("enabled event not latched in status");

  stat_no_set_a: assert property (@(posedge clk) disable iff (rst)
    !(|evt_hit) |=> (stat_ff & ~$past(stat_ff)) == 5'h00)
    else $error("status bit set without enabled event");

  irq_quiet_a: assert property (@(posedge clk) disable iff (rst)
    !(|(stat_ff & mask_ff)) && !(|evt_hit) |=> !irq)
    else $error("interrupt without unmasked status");

  // Status and mask access
  stat_clear_a: assert property (@(posedge clk) disable iff (rst)
    stat_read_s && !(|evt_hit) |=> (stat_ff & $past(prdata[4:0])) == 5'h00)
    else $error("status read did not clear reported bits");

  mask_load_a: assert property (@(posedge clk) disable iff (rst)
    mask_write_s |=> mask_ff == $past(pwdata[4:0]))
    else $error("mask write not applied");

  // Indicator messages and control fields
  ind_msg_state_a: assert property (@(posedge clk) disable iff (rst)
    ctrl_write_s |=> attn_msg_s($past(pwdata[7:6])) ##1 pwr_msg_s($past(pwdata[9:8], 2)))
    else $error("indicator message state wrong");

  msg_quiet_a: assert property (@(posedge clk) disable iff (rst)
    !ctrl_write_s ##1 !ctrl_write_s |=> !ind_msg.valid)
    else $error("indicator message without write");

  ctrl_hold_a: assert property (@(posedge clk) disable iff (rst)
    !ctrl_write_s |=> $stable(ctrl_ff))
    else $error("control changed without write");

  ctrl_load_a: assert property (@(posedge clk) disable iff (rst)
    ctrl_write_s |=> ctrl_ff == ($past(pwdata[15:0]) & HPSC_CTRL_WMASK))
    else $error("control write not masked");

  ind_hold_a: assert property (@(posedge clk) disable iff (rst)
    !ctrl_write_s |=> $stable(attn_ind) && $stable(pwr_ind))
    else $error("indicator changed without write");

  pwr_hold_a: assert property (@(posedge clk) disable iff (rst)
    !ctrl_write_s |=> $stable(slot_pwr_off))
    else $error("slot power changed without write");

  // Bus behaviour
  ctrl_read_a: assert property (@(posedge clk) disable iff (rst)
    ctrl_read_s |=> prdata == {16'h0000, $past(ctrl_ff)})
    else $error("control read data wrong");

  ctrl_decode_a: assert property (@(posedge clk) disable iff (rst)
    ctrl_read_s |=> pready && !pslverr)
    else $error("control offset not decoded");

  pready_pulse_a: assert property (@(posedge clk) disable iff (rst)
    psel && !penable |=> pready)
    else $error("no ready after setup");

  pready_once_a: assert property (@(posedge clk) disable iff (rst)
    pready |=> !pready)
    else $error("ready held beyond one cycle");

  slverr_ready_a: assert property (@(posedge clk) disable iff (rst)
    pslverr |-> pready)
    else $error("error response without ready");

  unmapped_read_a: assert property (@(posedge clk) disable iff (rst)
    psel && !penable && !pwrite && paddr != HPSC_SLOT_CTRL_OFF &&
      paddr != HPSC_INT_STAT_OFF && paddr != HPSC_INT_MASK_OFF
      |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped read not refused");
endmodule // hpsc_slot_control
`default_nettype wire

// ---- hpsc_slot_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module hpsc_slot_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Block side
  input wire hpsc_pkg::hpsc_ind_msg_type ind_msg,
  input wire logic [4:0] fire,
  output hpsc_pkg::hpsc_evt_type slot_evt,
  // Last indicator states shown
  output logic [1:0] attn_seen,
  output logic [1:0] pwr_seen
);
  import hpsc_pkg::*;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot_evt <= '0;
      attn_seen <= 2'h0;
      pwr_seen <= 2'h0;
    end else begin
      slot_evt <= hpsc_evt_type'(fire);
      if (ind_msg.valid && ind_msg.is_power) pwr_seen <= ind_msg.state;
      if (ind_msg.valid && !ind_msg.is_power) attn_seen <= ind_msg.state;
    end
  end
endmodule // hpsc_slot_model
`default_nettype wire

// ---- hotplug_slot_control_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module hotplug_slot_control_tb_top;
  import hpsc_pkg::*;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic err = 1'b0;
  int n_notify = 0;
  logic pready, pslverr, hp_notify, irq, slot_pwr_off;
  logic [1:0] attn_ind, pwr_ind, attn_seen, pwr_seen;
  logic [4:0] fire = '0;
  hpsc_evt_type slot_evt;
  hpsc_ind_msg_type ind_msg;
  int n_errors = 0, n_compared = 0;
  int ebit [5] = '{0, 1, 3, 4, 12};
  hpsc_slot_control dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .slot_evt, .attn_ind, .pwr_ind, .slot_pwr_off, .ind_msg,
    .hp_notify, .irq);
  hpsc_slot_model partner (.clk, .rst, .ind_msg, .fire, .slot_evt, .attn_seen, .pwr_seen);
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(negedge clk) if (hp_notify === 1'b1) n_notify++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(negedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(input logic [4:0] v);
    fire <= v;
    @(posedge clk);
    fire <= 5'h00;
    repeat (4) @(posedge clk);
  endtask
  task automatic complete_run;
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #50us;
    n_errors++;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, HPSC_SLOT_CTRL_OFF, 32'h0);
    chk(rd, 32'h000003C0);
    chk({pwr_ind, attn_ind, slot_pwr_off}, 32'h1E);
    apb(1'b1, HPSC_SLOT_CTRL_OFF, 32'hFFFFFFFF);
    apb(1'b0, HPSC_SLOT_CTRL_OFF, 32'h0);
    chk(rd, 32'h000017FB);
    apb(1'b1, HPSC_SLOT_CTRL_OFF, 32'h00000640);
    repeat (4) @(posedge clk);
    chk({pwr_ind, attn_ind, slot_pwr_off}, 32'h13);
    chk({pwr_seen, attn_seen}, 32'h9);
    apb(1'b1, HPSC_INT_MASK_OFF, 32'h1F);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, HPSC_SLOT_CTRL_OFF, 32'h3E0 | (32'h1 << ebit[i]));
      pulse(5'h1F);
      chk(irq, 32'h1);
      apb(1'b0, HPSC_INT_STAT_OFF, 32'h0);
      chk(rd, 32'h1 << i);
      repeat (3) @(posedge clk);
      chk(irq, 32'h0);
    end
    apb(1'b1, HPSC_SLOT_CTRL_OFF, 32'h13DB);
    pulse(5'h1F);
    apb(1'b0, HPSC_INT_STAT_OFF, 32'h0);
    chk(rd, 32'h0);
    chk(n_notify, 32'h5);
    apb(1'b0, 12'h0F0, 32'h0);
    chk(err, 32'h1);
    chk(rd, 32'h0);
    complete_run;
  end
endmodule // hotplug_slot_control_tb_top
`default_nettype wire
